// ### rxd_exec.v
// Executor for memory exchange, immediate load and table read instructions
`timescale 1ns/10ps
`include "rxd_map.vh"
module rxd_exec (
    input wire mclk, // Core clock, 125 MHz
    input wire nrst, // Asynchronous reset, active low
    input wire instr_valid, // Instruction word present this cycle
    input wire [9:0] instr, // Instruction word from program memory
    input wire [9:0] rom_data, // Word fetched at table address
    input wire [3:0] mem_rdata, // Nibble at addressed data memory
    input wire [2:0] dreg, // Register D, middle table address bits
    input wire [6:0] pc_now, // Current program counter from core
    output reg [3:0] acc, // Accumulator
    output reg [3:0] breg, // Register B
    output reg [3:0] xreg, // Low pointer register
    output reg [3:0] yreg, // Data pointer step register
    output reg [1:0] table_high_bits, // Table high register
    output reg mem_we, // Data memory write strobe
    output reg [3:0] mem_wdata, // Data memory write nibble
    output reg skip_next, // Skip pending; after a load it hits only a further load
    output reg busy, // Table read in progress, hold fetch
    output reg [13:0] rom_addr, // Table address to program memory
    output reg rom_rd, // Table fetch strobe
    output reg [2:0] stack_ptr, // Return stack pointer
    output reg [6:0] ret_pc // Saved return page/address
);

    // Sequencer state codes
    localparam [1:0] ST_RUN = `RXD_ST_RUN; // Executing from the fetch stream
    localparam [1:0] ST_TFETCH = `RXD_ST_TFETCH; // Table word on the program bus
    localparam [1:0] ST_TRET = `RXD_ST_TRET; // Return to the saved point

    // Decoded fields
    wire [5:0] opc = instr[9:4]; // Opcode class
    wire [3:0] imm = instr[3:0]; // Immediate nibble
    wire is_lmem = (opc == `RXD_OP_LOAD_MEM); // Memory into accumulator
    wire is_xchg = (opc == `RXD_OP_XCHG); // Plain exchange
    wire is_xinc = (opc == `RXD_OP_XCHG_INC); // Exchange, pointer up
    wire is_xdec = (opc == `RXD_OP_XCHG_DEC); // Exchange, pointer down
    wire is_smem = (opc == `RXD_OP_STORE_MEM); // Accumulator into memory
    wire is_limm = (opc == `RXD_OP_LOAD_IMM); // Immediate load
    wire is_tabl = (instr[9:6] == `RXD_OP_TABLE); // Table read, page in bits 5..0
    wire any_x = is_xchg | is_xinc | is_xdec; // Any exchange variant

    // Pointer wraps naturally at four bits
    wire [3:0] y_inc = yreg + 4'h1;
    wire [3:0] y_dec = yreg - 4'h1;
    reg [1:0] phase; // Table read phase
    reg last_limm; // Previous offered slot was an immediate load

    // A pending skip seen after a load can only come from that load, so it
    // hits a further load only; anything else after the run must execute
    wire skip_now = skip_next & (is_limm | ~last_limm);

    // Low pointer mixed with the immediate, one gate per bit
    wire [3:0] x_mix; // Candidate low pointer
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_xmix
            assign x_mix[gi] = xreg[gi] ^ imm[gi];
        end
    endgenerate

    // Next values, settled by the decode process below
    reg [3:0] next_acc; // Accumulator
    reg [3:0] next_breg; // Register B
    reg [3:0] next_xreg; // Low pointer
    reg [3:0] next_yreg; // Step register
    reg [1:0] next_th; // Table high bits
    reg next_we; // Memory write strobe
    reg [3:0] next_wdata; // Memory write nibble
    reg next_skip; // Skip pending
    reg next_busy; // Table read in progress
    reg [13:0] next_rom_addr; // Table address
    reg next_rom_rd; // Table fetch strobe
    reg [2:0] next_sp; // Stack level
    reg [6:0] next_ret_pc; // Saved return point
    reg [1:0] next_phase; // Sequencer state
    reg next_last_limm; // Run tracking

    // Instruction decode and table read sequencing
    // Kept combinational so that every output below is a plain flip-flop
    always @* begin
        // Hold everything but the two strobes unless a branch says otherwise
        next_acc = acc;
        next_breg = breg;
        next_xreg = xreg;
        next_yreg = yreg;
        next_th = table_high_bits;
        next_we = 1'b0; // Strobes are one-cycle pulses
        next_wdata = mem_wdata;
        next_skip = skip_next;
        next_busy = busy;
        next_rom_addr = rom_addr;
        next_rom_rd = 1'b0;
        next_sp = stack_ptr;
        next_ret_pc = ret_pc;
        next_phase = phase;
        next_last_limm = last_limm;
        case (phase)
            ST_RUN: begin
                if (instr_valid && skip_now) begin
                    // Skipped slot uses its cycle, only the skip and run tracking move
                    next_skip = is_limm & last_limm;
                    next_last_limm = is_limm;
                end else if (instr_valid) begin
                    // Executed slot: a fresh skip decision each time
                    next_skip = 1'b0;
                    next_last_limm = is_limm;
                    if (is_limm) begin
                        // Immediate into the accumulator
                        next_acc = imm;
                        // Later loads of the run are skipped
                        next_skip = 1'b1;
                    end else if (is_lmem) begin
                        // Memory nibble into the accumulator
                        next_acc = mem_rdata;
                        next_xreg = x_mix;
                    end else if (is_smem) begin
                        // Accumulator out to memory
                        next_we = 1'b1;
                        next_wdata = acc;
                        next_xreg = x_mix;
                    end else if (any_x) begin
                        // Swap accumulator and memory nibble
                        next_acc = mem_rdata;
                        next_we = 1'b1;
                        next_wdata = acc;
                        next_xreg = x_mix;
                        if (is_xdec) begin
                            // Step down, skip when the pointer wraps to 15
                            next_yreg = y_dec;
                            next_skip = (y_dec == `RXD_WRAP_DEC);
                        end else if (is_xinc) begin
                            // Step up, skip when the pointer wraps to 0
                            next_yreg = y_inc;
                            next_skip = (y_inc == `RXD_WRAP_INC);
                        end
                    end else if (is_tabl) begin
                        // Push return point, redirect fetch to table
                        next_sp = stack_ptr + 3'h1;
                        next_ret_pc = pc_now;
                        // Address bit 0 is unused and held low
                        next_rom_addr = {instr[5:0], dreg, acc, 1'b0};
                        next_rom_rd = 1'b1;
                        next_busy = 1'b1;
                        next_phase = ST_TFETCH;
                    end else begin
                        // Instructions outside this group leave these registers alone
                        next_last_limm = 1'b0;
                    end
                end
            end
            ST_TFETCH: begin
                // Word is on the bus in the same cycle as the strobe
                next_th = rom_data[`RXD_TH_HI:`RXD_TH_LO];
                next_breg = rom_data[`RXD_B_HI:`RXD_B_LO];
                next_acc = rom_data[`RXD_A_HI:`RXD_A_LO];
                next_phase = ST_TRET;
            end
            ST_TRET: begin
                // Pop the level, give fetch back (three cycles total)
                next_sp = stack_ptr - 3'h1;
                next_busy = 1'b0;
                next_phase = ST_RUN;
            end
            default: begin
                // Unused code: fall back to normal execution
                next_phase = ST_RUN;
                next_busy = 1'b0;
            end
        endcase
    end

    // State registers; every output comes straight from here
    // Reset loads constants only, so the async branch stays clean
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc <= `RXD_RST_NIB;
            breg <= `RXD_RST_NIB;
            xreg <= `RXD_RST_NIB;
            yreg <= `RXD_RST_NIB;
            table_high_bits <= `RXD_RST_TH;
            mem_we <= 1'b0;
            mem_wdata <= `RXD_RST_NIB;
            skip_next <= 1'b0;
            busy <= 1'b0;
            rom_addr <= `RXD_RST_ADDR;
            rom_rd <= 1'b0;
            stack_ptr <= `RXD_RST_SP;
            ret_pc <= `RXD_RST_PTR;
            phase <= ST_RUN;
            last_limm <= 1'b0;
        end else begin
            acc <= next_acc;
            breg <= next_breg;
            xreg <= next_xreg;
            yreg <= next_yreg;
            table_high_bits <= next_th;
            mem_we <= next_we;
            mem_wdata <= next_wdata;
            skip_next <= next_skip;
            busy <= next_busy;
            rom_addr <= next_rom_addr;
            rom_rd <= next_rom_rd;
            stack_ptr <= next_sp;
            ret_pc <= next_ret_pc;
            phase <= next_phase;
            last_limm <= next_last_limm;
        end
    end
endmodule

// ### rxd_exec_chk.sv
// Assertion checker for the exchange, load and table read executor
`timescale 1ns/10ps
module rxd_exec_chk(input wire mclk, nrst, instr_valid, busy, skip_next, mem_we, rom_rd,
    input wire [9:0] instr, rom_data, input wire [3:0] mem_rdata, acc, breg, xreg, yreg, mem_wdata,
    input wire [2:0] dreg, stack_ptr, input wire [1:0] table_high_bits, input wire [13:0] rom_addr);
    reg prev_lim; // Last offered slot was an immediate load
    // Run tracking over the slots the core offers
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_lim <= 1'b0;
        end else if (instr_valid && !busy) begin
            prev_lim <= (instr[9:4] == 6'h07);
        end
    end
    // A pending skip after a load only hits a further load
    wire skp = instr_valid & ~busy & skip_next & ((instr[9:4] == 6'h07) | ~prev_lim); // Slot skipped
    wire ex = instr_valid & ~busy & ~skp; // Instruction really executes
    wire [5:0] op = instr[9:4]; // Opcode class
    wire [3:0] imm = instr[3:0]; // Immediate field
    wire [13:0] taddr = {instr[5:0], dreg, acc, 1'b0}; // Table address
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_dec_wrap: assert property (ex && op == 6'h2F |=>
        yreg == $past(yreg) - 4'h1 && skip_next == (yreg == 4'hF)) else $error("decrement step wrong");
    a_inc_wrap: assert property (ex && op == 6'h2E |=>
        yreg == $past(yreg) + 4'h1 && skip_next == (yreg == 4'h0)) else $error("increment step wrong");
    a_swap_mem: assert property (ex && op inside {6'h2D, 6'h2E, 6'h2F} |=>
        acc == $past(mem_rdata) && mem_we && mem_wdata == $past(acc)) else $error("swap wrong");
    a_low_xor: assert property (ex && op inside {[6'h2B:6'h2F]} |=>
        xreg == ($past(xreg) ^ $past(imm))) else $error("low pointer wrong");
    a_store_acc: assert property (ex && op == 6'h2B |=>
        mem_we && mem_wdata == $past(acc) && $stable(acc)) else $error("store wrong");
    a_imm_acc: assert property (ex && op == 6'h07 |=> acc == $past(imm) && !mem_we)
        else $error("immediate load wrong");
    a_skip_quiet: assert property (skp |=>
        $stable(acc) && $stable(xreg) && $stable(yreg) && !mem_we) else $error("skipped op acted");
    a_run_skip: assert property (skp && op == 6'h07 && prev_lim |=> skip_next)
        else $error("load run not skipped");
    a_table_seq: assert property (ex && instr[9:6] == 4'h2 |=>
        busy && rom_rd && rom_addr == $past(taddr) && stack_ptr == $past(stack_ptr) + 3'h1
        ##1 busy && !rom_rd && {table_high_bits, breg, acc} == $past(rom_data)
        ##1 !busy && stack_ptr == $past(stack_ptr, 3)) else $error("table read wrong");
endmodule
bind rxd_exec rxd_exec_chk u_chk (.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .busy(busy),
    .skip_next(skip_next), .mem_we(mem_we), .rom_rd(rom_rd), .instr(instr), .rom_data(rom_data),
    .mem_rdata(mem_rdata), .acc(acc), .breg(breg), .xreg(xreg), .yreg(yreg), .mem_wdata(mem_wdata),
    .dreg(dreg), .stack_ptr(stack_ptr), .table_high_bits(table_high_bits), .rom_addr(rom_addr));

// ### rxd_exec_tb.sv
// Self-checking bench for the exchange, load and table read executor
`timescale 1ns/10ps
module rxd_exec_tb;
    reg mclk = 1'b0; // Core clock
    reg nrst = 1'b0; // Reset, active low
    reg instr_valid = 1'b0; // Instruction strobe
    reg [9:0] instr = 10'h000; // Instruction word
    wire [3:0] acc, breg, xreg, yreg, mem_wdata; // Datapath outputs
    wire [1:0] table_high_bits; // Table high bits
    wire [13:0] rom_addr; // Table address
    wire [2:0] stack_ptr; // Stack level
    wire [6:0] ret_pc; // Saved return point
    wire mem_we, skip_next, busy, rom_rd; // Strobes
    wire [12:0] st = {acc, xreg, yreg, mem_we}; // Compact state view
    integer err_total = 0; // Mismatches
    integer checked = 0; // Comparisons
    integer cyc = 0; // Cycles for the hang guard
    // Memory reads 4'hA and table word 10'h2A7 throughout
    rxd_exec dut(.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr), .rom_data(10'h2A7),
        .mem_rdata(4'hA), .dreg(3'h5), .pc_now(7'h11), .acc(acc), .breg(breg), .xreg(xreg), .yreg(yreg),
        .table_high_bits(table_high_bits), .mem_we(mem_we), .mem_wdata(mem_wdata), .skip_next(skip_next),
        .busy(busy), .rom_addr(rom_addr), .rom_rd(rom_rd), .stack_ptr(stack_ptr), .ret_pc(ret_pc));
    initial forever #4 mclk = ~mclk; // 8 ns period
    task stop_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [19:0] e, input logic [19:0] g);
        checked = checked + 1;
        if (e !== g) begin
            err_total = err_total + 1;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task exe(input logic [9:0] i); // Present one instruction, taken next edge
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= i;
    endtask
    task stp(input logic [9:0] i, input logic [12:0] e); // One instruction, then judge state
        exe(i);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk("state", e, st);
    endtask
    task t_step; // Stepping exchanges wrap and skip the following op
        stp(10'h075, {4'h5, 4'h0, 4'h0, 1'b0});
        stp(10'h2F3, {4'hA, 4'h3, 4'hF, 1'b1});
        chk("wdata", 4'h5, mem_wdata);
        stp(10'h2B1, {4'hA, 4'h3, 4'hF, 1'b0});
        stp(10'h2E6, {4'hA, 4'h5, 4'h0, 1'b1});
        stp(10'h2C4, {4'hA, 4'h5, 4'h0, 1'b0});
        stp(10'h2DF, {4'hA, 4'hA, 4'h0, 1'b1});
        chk("skip", 1'b0, skip_next);
    endtask
    task t_run; // Back to back loads: only the first lands
        exe(10'h071);
        exe(10'h072);
        stp(10'h073, {4'h1, 4'hA, 4'h0, 1'b0});
        stp(10'h2B0, {4'h1, 4'hA, 4'h0, 1'b1});
        chk("wdata", 4'h1, mem_wdata);
        stp(10'h2C2, {4'hA, 4'h8, 4'h0, 1'b0});
    endtask
    task t_table; // Table read over three cycles, one stack level
        exe(10'h083);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk("fetch", {1'b1, 1'b1, 3'h1, 14'h03B4}, {busy, rom_rd, stack_ptr, rom_addr});
        chk("ret", 7'h11, ret_pc);
        repeat (2) @(posedge mclk);
        #1;
        chk("table", {2'h2, 4'hA, 4'h7, 3'h0, 1'b0}, {table_high_bits, breg, acc, stack_ptr, busy});
    endtask
    // Hang guard: the whole run needs well under 100 cycles
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 500) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_step;
        t_run;
        t_table;
        stop_test;
    end
endmodule

// ### rxd_map.vh
// Constants for the memory exchange and table fetch executor
`ifndef RXD_MAP_VH
`define RXD_MAP_VH
// Opcode classes, compared against bits 9..4 of the instruction
`define RXD_OP_LOAD_MEM 6'h2C
`define RXD_OP_XCHG 6'h2D
`define RXD_OP_XCHG_INC 6'h2E
`define RXD_OP_XCHG_DEC 6'h2F
`define RXD_OP_STORE_MEM 6'h2B
`define RXD_OP_LOAD_IMM 6'h07
// Table read: bits 9..6 equal 4'h2, bits 5..0 carry the page
`define RXD_OP_TABLE 4'h2
// Fetched word field positions
`define RXD_TH_HI 9
`define RXD_TH_LO 8
`define RXD_B_HI 7
`define RXD_B_LO 4
`define RXD_A_HI 3
`define RXD_A_LO 0
// Wrap values for the step skips
`define RXD_WRAP_DEC 4'hF
`define RXD_WRAP_INC 4'h0
// Reset values
`define RXD_RST_NIB 4'h0
`define RXD_RST_TH 2'h0
`define RXD_RST_PTR 7'h00
`define RXD_RST_SP 3'h0
`define RXD_RST_ADDR 14'h0000
// Table read phases
`define RXD_ST_RUN 2'h0
`define RXD_ST_TFETCH 2'h1
`define RXD_ST_TRET 2'h2
`endif
